//--- hw/adcc_regs.svh
// Register-level constants of the converter calibration and coding block.
// Included by the package user; no surrounding bus is assumed.
`ifndef ADCC_REGS_SVH
`define ADCC_REGS_SVH
`define ADCC_OP_IDLE      3'h0
`define ADCC_OP_SINGLE    3'h2
`define ADCC_OP_CONT      3'h3
`define ADCC_OP_INT_ZERO  3'h4
`define ADCC_OP_INT_FULL  3'h5
`define ADCC_OP_SYS_ZERO  3'h6
`define ADCC_OP_SYS_FULL  3'h7
`define ADCC_OP_CAL_BIT   2
`define ADCC_OP_FULL_BIT  0
`define ADCC_OP_SYS_BIT   1
`define ADCC_RANGE_RST    3'h0
`define ADCC_EXC_RST      4'h0
`define ADCC_MIDSCALE_BIT 23
`define ADCC_GAIN_UNITY   24'h800000
`define ADCC_OFFSET_ZERO  24'h000000
`endif

//--- hw/adcc_pkg.sv
// Types of the converter calibration and coding block.
// Needs nothing from its surroundings.
package adcc_pkg;
  typedef enum logic [3:0] {
    ADCC_IDLE = 4'b0001,
    ADCC_CONV = 4'b0010,
    ADCC_CAL  = 4'b0100,
    ADCC_HOLD = 4'b1000
  } adcc_state_t;
  typedef enum logic [1:0] {
    ADCC_SRC_PINS = 2'h0,
    ADCC_SRC_ZERO = 2'h1,
    ADCC_SRC_FULL = 2'h2
  } adcc_src_t;
endpackage

//--- hw/adcc_core.sv
// Calibration control, offset/gain correction and output coding.
// Assumes filter words arrive as a one-cycle strobe at the decimation rate
// set by the modulator side; the factory store answers a load request.
//
// Notes on behaviour
// - Op field 100 starts internal zero calibration into offset.
// - Op field 101 starts internal full calibration into gain.
// - Op field 110 starts system zero calibration using pin voltage.
// - Op field 111 starts system full calibration using pin voltage.
// - After reset, factory coefficients load into calibration registers.
// - A finished user calibration overwrites the factory coefficient.
// - Zero-scale result is written into the offset coefficient.
// - Full-scale result is written into the gain coefficient.
// - Internal calibration routes zero or full reference, not pins.
// - Calibration takes the next filter word at normal rate.
// - Subtract offset first, then multiply by normalized gain.
// - Ready flag marks end of calibration.
// - Missing reference during calibration halts it, no write.
// - Three-bit range field selects eight gain ranges, 128 to 1.
// - Auxiliary converter has fixed gain, no range field.
// - Unipolar output is straight binary.
// - Bipolar output is offset binary, zero input gives midscale.
// - Result width 24 bits, or 16 in reduced variant.
// - Low four bits of current-source control drive excitation pins.
// - Ready set on completion; blocks further writes until cleared.
// - Calibration flag set on completion, cleared by mode write.
// - Missing reference clamps results to all ones.
// - Calibration blocked by bad reference sets error flag.
`timescale 1ns/1ps
`include "adcc_regs.svh"

module adcc_core #(
  parameter int RES_W = 24
) (
  input  wire logic               core_clk_i,
  input  wire logic               rst_i,
  input  wire logic               conv_enable_i,
  input  wire logic               mode_wr_i,
  input  wire logic [2:0]         operation_select_field_i,
  input  wire logic               bipolar_i,
  input  wire logic [2:0]         gain_range_field_i,
  input  wire logic [3:0]         current_source_control_i,
  input  wire logic               ready_clr_i,
  input  wire logic               ref_missing_flag_i,
  input  wire logic               filt_valid_i,
  input  wire logic [RES_W-1:0]   filt_word_i,
  input  wire logic               fact_valid_i,
  input  wire logic [RES_W-1:0]   fact_offset_i,
  input  wire logic [RES_W-1:0]   fact_gain_i,
  output logic                    fact_req_o,
  output logic [1:0]              input_src_o,
  output logic [2:0]              gain_amplifier_o,
  output logic [3:0]              excitation_en_o,
  output logic [RES_W-1:0]        offset_coef_o,
  output logic [RES_W-1:0]        gain_coef_o,
  output logic [RES_W-1:0]        result_o,
  output logic                    result_valid_o,
  output logic                    primary_done_flag_o,
  output logic                    cal_done_flag_o,
  output logic                    primary_error_flag_o,
  output logic                    busy_o
);

  localparam int PW = 2 * RES_W + 1;

  adcc_pkg::adcc_state_t state_q;
  logic [2:0]            op_q;
  logic                  cont_q;
  logic signed [PW-1:0]  diff_s;
  logic signed [PW-1:0]  prod_s;
  logic [RES_W-1:0]      corr_w;
  logic [RES_W-1:0]      coded_w;
  logic                  blocked_w;
  logic                  cal_word_w;
  logic                  conv_word_w;

  // Any result write stalls while ready is still pending
  // write inhibit
  assign blocked_w   = primary_done_flag_o;
  assign cal_word_w  = (state_q == adcc_pkg::ADCC_CAL) && filt_valid_i
                       && !blocked_w;
  assign conv_word_w = (state_q == adcc_pkg::ADCC_CONV) && filt_valid_i
                       && !blocked_w;

  always_comb begin
    diff_s = PW'($signed({1'b0, filt_word_i}))
           - PW'($signed({1'b0, offset_coef_o}));
    prod_s = (diff_s * PW'($signed({1'b0, gain_coef_o}))) >>> (RES_W - 1);
    if (prod_s < 0) begin
      corr_w = '0;
    end else if (prod_s > PW'($signed({1'b0, {RES_W{1'b1}}}))) begin
      corr_w = '1;
    end else begin
      corr_w = prod_s[RES_W-1:0];
    end
  end

  // Unipolar words are already straight binary; bipolar flips the sign bit
  // output coding
  always_comb begin
    coded_w = corr_w;
    if (bipolar_i) begin
      coded_w[RES_W-1] = ~corr_w[RES_W-1];
    end
  end

  // Mode writes while the converter is off still latch the op field but send it to idle
  // mode decode
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= adcc_pkg::ADCC_HOLD;
      op_q    <= `ADCC_OP_IDLE;
      cont_q  <= 1'b0;
    end else if (state_q == adcc_pkg::ADCC_HOLD) begin
      if (fact_valid_i) begin
        state_q <= adcc_pkg::ADCC_IDLE;
      end
    end else if (mode_wr_i) begin
      op_q   <= operation_select_field_i;
      cont_q <= (operation_select_field_i == `ADCC_OP_CONT);
      if (!conv_enable_i || operation_select_field_i == `ADCC_OP_IDLE) begin
        state_q <= adcc_pkg::ADCC_IDLE;
      end else if (operation_select_field_i[`ADCC_OP_CAL_BIT]) begin
        state_q <= adcc_pkg::ADCC_CAL;
      end else begin
        state_q <= adcc_pkg::ADCC_CONV;
      end
    end else begin
      case (state_q)
        adcc_pkg::ADCC_CAL: begin
          if (ref_missing_flag_i || cal_word_w) begin
            state_q <= adcc_pkg::ADCC_IDLE;
          end
        end
        adcc_pkg::ADCC_CONV: begin
          if (conv_word_w && !cont_q) begin
            state_q <= adcc_pkg::ADCC_IDLE;
          end
        end
        adcc_pkg::ADCC_IDLE: state_q <= adcc_pkg::ADCC_IDLE;
        default:            state_q <= adcc_pkg::ADCC_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      fact_req_o <= 1'b1;
    end else if (fact_valid_i) begin
      fact_req_o <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      offset_coef_o <= RES_W'(`ADCC_OFFSET_ZERO);
      gain_coef_o   <= RES_W'(`ADCC_GAIN_UNITY >> (24 - RES_W));
    end else if (state_q == adcc_pkg::ADCC_HOLD) begin
      if (fact_valid_i) begin
        offset_coef_o <= fact_offset_i;
        gain_coef_o   <= fact_gain_i;
      end
    end else if (cal_word_w && !ref_missing_flag_i && !mode_wr_i) begin
      if (op_q[`ADCC_OP_FULL_BIT]) begin
        gain_coef_o <= filt_word_i;
      end else begin
        offset_coef_o <= filt_word_i;
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      result_o       <= '0;
      result_valid_o <= 1'b0;
    end else begin
      result_valid_o <= conv_word_w && !mode_wr_i;
      if (conv_word_w && !mode_wr_i) begin
        result_o <= ref_missing_flag_i ? '1 : coded_w;
      end
    end
  end

  // Set outranks the software clear in the same cycle
  // ready flag
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      primary_done_flag_o <= 1'b0;
    end else if (!mode_wr_i && ((cal_word_w && !ref_missing_flag_i)
                 || conv_word_w
                 || (state_q == adcc_pkg::ADCC_CAL && ref_missing_flag_i))) begin
      primary_done_flag_o <= 1'b1;
    end else if (ready_clr_i || mode_wr_i) begin
      primary_done_flag_o <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cal_done_flag_o <= 1'b0;
    end else if (!mode_wr_i && cal_word_w && !ref_missing_flag_i) begin
      cal_done_flag_o <= 1'b1;
    end else if (mode_wr_i) begin
      cal_done_flag_o <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      primary_error_flag_o <= 1'b0;
    end else if (!mode_wr_i && ((state_q == adcc_pkg::ADCC_CAL
                 && ref_missing_flag_i)
                 || (conv_word_w && ref_missing_flag_i))) begin
      primary_error_flag_o <= 1'b1;
    end else if (mode_wr_i) begin
      primary_error_flag_o <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      input_src_o <= adcc_pkg::ADCC_SRC_PINS;
    end else if (state_q == adcc_pkg::ADCC_CAL && !op_q[`ADCC_OP_SYS_BIT]) begin
      input_src_o <= op_q[`ADCC_OP_FULL_BIT] ? adcc_pkg::ADCC_SRC_FULL
                                             : adcc_pkg::ADCC_SRC_ZERO;
    end else begin
      input_src_o <= adcc_pkg::ADCC_SRC_PINS;
    end
  end

  // Internal full scale is taken at unity gain
  // Auxiliary path has no range logic here: its span is fixed
  // range and excitation
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      gain_amplifier_o <= `ADCC_RANGE_RST;
      excitation_en_o  <= `ADCC_EXC_RST;
      busy_o           <= 1'b1;
    end else begin
      gain_amplifier_o <= (state_q == adcc_pkg::ADCC_CAL
                           && op_q == `ADCC_OP_INT_FULL)
                          ? 3'h7 : gain_range_field_i;
      excitation_en_o  <= current_source_control_i;
      busy_o           <= state_q != adcc_pkg::ADCC_IDLE;
    end
  end

endmodule

//--- verification/adcc_core_properties.sv
// Port checker of the calibration core.
// Bound into every adcc_core instance below.
`timescale 1ns/1ps
module adcc_props #(parameter int RES_W = 24) (
  input logic             core_clk_i,
  input logic             rst_i,
  input logic             conv_enable_i,
  input logic             mode_wr_i,
  input logic [2:0]       operation_select_field_i,
  input logic             ref_missing_flag_i,
  input logic [RES_W-1:0] filt_word_i,
  input logic             fact_valid_i,
  input logic [RES_W-1:0] fact_offset_i,
  input logic             fact_req_o,
  input logic [1:0]       input_src_o,
  input logic [RES_W-1:0] offset_coef_o,
  input logic [RES_W-1:0] gain_coef_o,
  input logic [RES_W-1:0] result_o,
  input logic             result_valid_o,
  input logic             primary_done_flag_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  logic go;
  assign go = mode_wr_i && conv_enable_i && !fact_req_o;
  fact_load_a:
    assert property (fact_req_o && fact_valid_i |=> !fact_req_o &&
      offset_coef_o == $past(fact_offset_i)) else $error("load");
  zero_src_a:
    assert property (go && operation_select_field_i == 3'h4 |->
      ##2 input_src_o == 2'h1) else $error("zero src");
  full_src_a:
    assert property (go && operation_select_field_i == 3'h5 |->
      ##2 input_src_o == 2'h2) else $error("full src");
  offset_wr_a:
    assert property ($changed(offset_coef_o) && !$past(fact_req_o) |->
      offset_coef_o == $past(filt_word_i) && primary_done_flag_o)
      else $error("offset");
  gain_wr_a:
    assert property ($changed(gain_coef_o) && !$past(fact_req_o) |->
      gain_coef_o == $past(filt_word_i) && primary_done_flag_o)
      else $error("gain");
  ref_halt_a:
    assert property (ref_missing_flag_i && !fact_req_o |=>
      $stable(offset_coef_o) && $stable(gain_coef_o)) else $error("halt");
  clamp_ones_a:
    assert property (result_valid_o && $past(ref_missing_flag_i) &&
      $past(ref_missing_flag_i, 2) |-> &result_o) else $error("clamp");
  ready_block_a:
    assert property (primary_done_flag_o |=> $stable(offset_coef_o) &&
      $stable(gain_coef_o)) else $error("blocked");
  cover property (go && operation_select_field_i == 3'h7);
  cover property ($rose(primary_done_flag_o));
  cover property (result_valid_o && &result_o);
endmodule
bind adcc_core adcc_props #(.RES_W(RES_W)) props_u (.*);

//--- verification/adcc_front_model.sv
// Factory store and filter word source facing the core.
// Shares the core clock; words are sent on the bench's call.
`timescale 1ns/1ps
module adcc_front_model (
  input  wire logic  core_clk_i,
  input  wire logic  rst_i,
  input  wire logic  fact_req_i,
  output logic       fact_valid_o,
  output logic [23:0] fact_offset_o,
  output logic [23:0] fact_gain_o,
  output logic       filt_valid_o = 1'b0,
  output logic [23:0] filt_word_o = 24'h0
);
  logic [2:0] dly_q;
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) dly_q <= 3'h0;
    else if (fact_req_i && dly_q != 3'h7) dly_q <= dly_q + 3'h1;
  end
  assign fact_valid_o = fact_req_i && dly_q == 3'h7;
  // Data inverted when not valid, never a stale copy
  assign fact_offset_o = fact_valid_o ? 24'h000010 : 24'hFFFFEF;
  assign fact_gain_o = fact_valid_o ? 24'h800000 : 24'h7FFFFF;
  // word stands for settled pin voltage
  task automatic send(input logic [23:0] w);
    @(posedge core_clk_i);
    filt_valid_o <= 1'b1;
    filt_word_o <= w;
    @(posedge core_clk_i);
    filt_valid_o <= 1'b0;
    filt_word_o <= ~w;
  endtask
endmodule

//--- verification/adc_calibration_and_coding_tb.sv
// Bench of the calibration core: calibrations, coding, reference loss.
// Model supplies factory values and filter words.
`timescale 1ns/1ps
module adc_calibration_and_coding_tb;
  logic core_clk_i = 1'b0, rst_i = 1'b1, conv_enable_i = 1'b0;
  logic mode_wr_i = 1'b0, ready_clr_i = 1'b0, ref_missing_flag_i = 1'b0;
  logic bipolar_i = 1'b0;
  logic [2:0] operation_select_field_i = 3'h0, gain_range_field_i = 3'h5;
  logic [3:0] current_source_control_i = 4'hA, excitation_en_o;
  logic filt_valid_i, fact_valid_i, fact_req_o, result_valid_o, busy_o;
  logic primary_done_flag_o, cal_done_flag_o, primary_error_flag_o;
  logic [1:0] input_src_o;
  logic [2:0] gain_amplifier_o;
  logic [23:0] filt_word_i, fact_offset_i, fact_gain_i;
  logic [23:0] offset_coef_o, gain_coef_o, result_o;
  logic [23:0] wd [4] = '{24'h20, 24'h800000, 24'h30, 24'h800000};
  logic [1:0] sx [4] = '{2'h1, 2'h2, 2'h0, 2'h0};
  int fail_count = 0;
  int n_tests = 0;
  adcc_core dut_u (.*);
  adcc_front_model model_u (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .fact_req_i(fact_req_o), .fact_valid_o(fact_valid_i),
    .fact_offset_o(fact_offset_i), .fact_gain_o(fact_gain_i),
    .filt_valid_o(filt_valid_i), .filt_word_o(filt_word_i));
  initial forever #4 core_clk_i = ~core_clk_i;
  task automatic chk(string nm, logic [23:0] exp, logic [23:0] got);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic till(ref logic s, input logic v);
    repeat (50) begin
      @(posedge core_clk_i);
      #1;
      if (s === v) break;
    end
  endtask
  task automatic mode(logic [2:0] o);
    @(posedge core_clk_i);
    mode_wr_i <= 1'b1;
    operation_select_field_i <= o;
    @(posedge core_clk_i);
    mode_wr_i <= 1'b0;
  endtask
  task automatic run(logic [23:0] w, logic c);
    model_u.send(w);
    till(primary_done_flag_o, 1'b1);
    @(posedge core_clk_i);
    #1;
    chk("ready", 24'h1, {23'h0, primary_done_flag_o});
    if (c) begin
      @(posedge core_clk_i);
      ready_clr_i <= 1'b1;
      @(posedge core_clk_i);
      ready_clr_i <= 1'b0;
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Whole run is well under 2000 cycles
  initial begin
    #200000;
    fail_count++;
    finish_test();
  end
  initial begin
    repeat (20) @(posedge core_clk_i);
    rst_i <= 1'b0;
    conv_enable_i <= 1'b1;
    till(fact_req_o, 1'b0);
    chk("offset", 24'h10, offset_coef_o);
    chk("gain", 24'h800000, gain_coef_o);
    chk("exc", 24'hA, {20'h0, excitation_en_o});
    for (int i = 0; i < 4; i++) begin
      mode(3'(4 + i));
      repeat (2) @(posedge core_clk_i);
      #1;
      chk("src", {22'h0, sx[i]}, {22'h0, input_src_o});
      chk("amp", i == 1 ? 24'h7 : 24'h5, {21'h0, gain_amplifier_o});
      run(wd[i], 1'b1);
      chk("cal", 24'h1, {23'h0, cal_done_flag_o});
      chk("coef", wd[i], i[0] ? gain_coef_o : offset_coef_o);
    end
    mode(3'h3);
    run(24'h130, 1'b0);
    chk("result", 24'h100, result_o);
    chk("busy", 24'h1, {23'h0, busy_o});
    model_u.send(24'h530);
    repeat (6) @(posedge core_clk_i);
    chk("held", 24'h100, result_o);
    bipolar_i <= 1'b1;
    mode(3'h2);
    run(24'h130, 1'b1);
    chk("bipolar", 24'h800100, result_o);
    ref_missing_flag_i <= 1'b1;
    mode(3'h4);
    run(24'h777, 1'b1);
    chk("kept", 24'h30, offset_coef_o);
    chk("err", 24'h1, {23'h0, primary_error_flag_o});
    mode(3'h2);
    run(24'h200, 1'b1);
    chk("clamp", 24'hFFFFFF, result_o);
    finish_test();
  end
endmodule
